// ### src/acr_pkg.sv
// shared constants of the converter control block
package acr_pkg;
	// register indices; byte address on the bus is four times the index
	localparam logic [7:0] IDX_RES_LO = 8'h78;
	localparam logic [7:0] IDX_RES_HI = 8'h79;
	localparam logic [7:0] IDX_CTRL   = 8'h7A;
	localparam logic [7:0] IDX_TRIG   = 8'h7B;
	localparam logic [7:0] IDX_MUX    = 8'h7C;
	// reset values
	localparam logic [7:0] RST_CTRL   = 8'h00;
	localparam logic [7:0] RST_MUX    = 8'h00;
	localparam logic [2:0] RST_TRIG   = 3'h0;
	localparam logic [9:0] RST_RESULT = 10'h000;
	// control and status field positions
	localparam int CTRL_EN    = 7;
	localparam int CTRL_START = 6;
	localparam int CTRL_ATE   = 5;
	localparam int CTRL_FLAG  = 4;
	localparam int CTRL_IE    = 3;
	localparam int CTRL_DIV   = 0;
	// input and reference select field positions
	localparam int MUX_REF  = 6;
	localparam int MUX_LEFT = 5;
	localparam int MUX_CHAN = 0;
	// conversion length in converter clock cycles
	localparam logic [4:0] FIRST_CYCLES  = 5'h19;
	localparam logic [4:0] NORMAL_CYCLES = 5'h0D;
	// trigger source code that means free running
	localparam logic [2:0] TRIG_FREE = 3'h0;
	// channel code boundaries
	localparam logic [4:0] CH_LAST_SINGLE = 5'h07;
	localparam logic [4:0] CH_LAST_DIFF   = 5'h1D;
	localparam logic [4:0] CH_BANDGAP     = 5'h1E;
	// reference source seen by the analog core
	typedef enum logic [1:0] {
		REF_EXT_PIN = 2'h0,
		REF_SUPPLY  = 2'h1,
		REF_INT_1V1 = 2'h2,
		REF_INT_2V56 = 2'h3
	} acr_ref_type;
	// kind of input connection
	typedef enum logic [1:0] {
		IN_SINGLE  = 2'h0,
		IN_DIFF    = 2'h1,
		IN_BANDGAP = 2'h2,
		IN_GROUND  = 2'h3
	} acr_kind_type;
	// amplifier gain of the differential path
	typedef enum logic [1:0] {
		GAIN_1X   = 2'h0,
		GAIN_10X  = 2'h1,
		GAIN_200X = 2'h2
	} acr_gain_type;
	// conversion sequencer state
	typedef enum logic [0:0] {
		ST_IDLE = 1'h0,
		ST_CONV = 1'h1
	} acr_state_type;
endpackage

// ### src/acr_clock_div.sv
`timescale 1ns/100ps
// converter clock enable: one pulse every 2 to 128 system clocks
module acr_clock_div (
	input  wire logic       clk_i,     // system clock
	input  wire logic       rst_i,     // synchronous reset
	input  wire logic       run_i,     // converter enabled
	input  wire logic [2:0] divider_i, // division code
	output logic            tick_o     // one-cycle converter clock enable
);
	logic [6:0] cnt_q; // cycles since the last pulse

	// division code to terminal count (factor minus one)
	function automatic logic [6:0] last_count(input logic [2:0] code);
		last_count = (code == 3'h0) ? 7'h01 : 7'((8'h01 << code) - 8'h01);
	endfunction

	// R16 prescaled converter clock
	always_ff @(posedge clk_i) begin
		if (rst_i || !run_i) begin
			cnt_q  <= 7'h00;
			tick_o <= 1'b0;
		end else if (cnt_q >= last_count(divider_i)) begin
			cnt_q  <= 7'h00;
			tick_o <= 1'b1;
		end else begin
			cnt_q  <= cnt_q + 7'h01;
			tick_o <= 1'b0;
		end
	end
endmodule // acr_clock_div

// ### src/acr_adc_ctrl.sv
`timescale 1ns/100ps
// Overview of operation
// R1: reference change waits for conversion end
// R2: reference codes: pin, supply, 1.1V, 2.56V
// R3: alignment change shows at once
// R4: align bit one left, zero right
// R5: codes 0-7 single, 30 bandgap, 31 ground
// R6: codes 8-29 differential pairs with gain
// R7: channel change waits for conversion end
// R8: enable on; disable aborts running conversion
// R9: start bit starts one, or first freerun
// R10: first conversion 25 cycles, later 13
// R11: start reads busy; writing zero ignored
// R12: auto trigger on selected rising edge
// R13: flag set with result register update
// R14: flag cleared by vector or writing one
// R15: interrupt when flag, enable, global enable
// R16: prescaler divides system clock 2 to 128
// R17: differential result two's complement
// R18: low byte read locks until high read
// R19: low byte at base, high at plus one
// R20: right aligned: bits 9:0, upper zero
// R21: left aligned: bits 15:6, lower zero
// R22: trigger select chooses auto trigger source
// R23: core port: sample, start, result latch
module acr_adc_ctrl (
	input  wire logic           clk_i,            // system clock
	input  wire logic           rst_i,            // synchronous reset
	input  wire logic [11:0]    wb_adr_i,         // byte address
	input  wire logic [31:0]    wb_dat_i,         // write data
	input  wire logic [3:0]     wb_sel_i,         // byte enables
	input  wire logic           wb_we_i,          // write
	input  wire logic           wb_cyc_i,         // cycle
	input  wire logic           wb_stb_i,         // strobe
	output logic [31:0]         wb_dat_o,         // read data
	output logic                wb_ack_o,         // acknowledge
	input  wire logic [7:0]     trigger_i,        // trigger sources by select code
	input  wire logic           global_irq_en_i,  // processor global enable
	input  wire logic           irq_ack_i,        // vector executed
	output logic                irq_o,            // conversion complete request
	input  wire logic           core_done_i,      // core result ready
	input  wire logic [9:0]     core_result_i,    // core raw result
	output logic                core_enable_o,    // core powered
	output logic                core_clk_en_o,    // converter clock enable
	output logic                core_sample_o,    // sample pulse at start
	output logic                core_busy_o,      // conversion running
	output logic                core_init_o,      // running conversion initialises
	output acr_pkg::acr_ref_type  core_ref_o,     // reference source
	output logic                core_int_ref_on_o, // internal reference powered
	output acr_pkg::acr_kind_type core_kind_o,    // input kind
	output logic [2:0]          core_pos_o,       // positive or single input
	output logic [1:0]          core_neg_o,       // negative input
	output acr_pkg::acr_gain_type core_gain_o     // gain
);
	logic [7:0]  mux_q;       // reference, alignment, channel
	logic        enable_q;    // converter enable
	logic        ate_q;       // auto trigger enable
	logic        flag_q;      // conversion done flag
	logic        ie_q;        // interrupt enable
	logic [2:0]  div_q;       // prescaler code
	logic [2:0]  trig_q;      // trigger source select
	acr_pkg::acr_state_type state_q; // sequencer state
	logic        need_init_q; // next conversion initialises
	logic [4:0]  len_q;       // length of running conversion
	logic [4:0]  cnt_q;       // converter cycles elapsed
	logic [9:0]  result_q;    // stored result, right aligned
	logic        lock_q;      // result locked after low byte read
	logic        trig_prev_q; // previous selected trigger level
	logic [4:0]  chan_q;      // channel applied to the core
	logic        tick;        // converter clock enable
	logic        req;         // new bus request
	logic        wr;          // register write
	logic [7:0]  idx;         // register index
	logic [7:0]  wdat;        // write byte
	logic        wr_ctrl;     // control register write
	logic        en_next;     // enable after this cycle
	logic        busy;        // conversion running
	logic        trig_edge;   // auto trigger event
	logic        start_go;    // conversion begins now
	logic        conv_done;   // conversion finishes now
	logic        res_write;   // result register update
	logic        free_run;    // restart after completion
	logic [15:0] shown;       // result as the data register shows it

	// result as seen in the 16-bit data register
	function automatic logic [15:0] present(input logic [9:0] r, input logic left);
		present = left ? {r, 6'h00} : {6'h00, r};
	endfunction

	// channel code to input kind
	function automatic acr_pkg::acr_kind_type kind_of(input logic [4:0] c);
		if (c <= acr_pkg::CH_LAST_SINGLE)
			kind_of = acr_pkg::IN_SINGLE;
		else if (c <= acr_pkg::CH_LAST_DIFF)
			kind_of = acr_pkg::IN_DIFF;
		else if (c == acr_pkg::CH_BANDGAP)
			kind_of = acr_pkg::IN_BANDGAP;
		else
			kind_of = acr_pkg::IN_GROUND;
	endfunction

	// bus decode
	assign req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign idx     = wb_adr_i[9:2];
	assign wdat    = wb_dat_i[7:0];
	assign wr      = req & wb_we_i & wb_sel_i[0] & (wb_adr_i[11:10] == 2'h0);
	assign wr_ctrl = wr & (idx == acr_pkg::IDX_CTRL);
	assign en_next = wr_ctrl ? wdat[acr_pkg::CTRL_EN] : enable_q;
	assign busy    = (state_q == acr_pkg::ST_CONV);
	assign shown   = present(result_q, mux_q[acr_pkg::MUX_LEFT]);

	// R22 selected trigger and its rising edge
	assign trig_edge = ate_q & (trig_q != acr_pkg::TRIG_FREE) & trigger_i[trig_q] & ~trig_prev_q;

	// R9 R12 software or trigger start
	assign start_go = en_next & ~busy &
		((wr_ctrl & wdat[acr_pkg::CTRL_START]) | trig_edge);

	// R23 completion needs full length and core ready
	assign conv_done = busy & enable_q & (cnt_q == len_q) & core_done_i;
	// R18 no update while locked
	assign res_write = conv_done & ~lock_q;
	// R9 free running restarts itself
	assign free_run  = ate_q & (trig_q == acr_pkg::TRIG_FREE);

	// converter clock divider
	acr_clock_div u_div (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.run_i     (enable_q),
		.divider_i (div_q),
		.tick_o    (tick)
	);

	// software written control fields
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mux_q    <= acr_pkg::RST_MUX;
			enable_q <= acr_pkg::RST_CTRL[acr_pkg::CTRL_EN];
			ate_q    <= acr_pkg::RST_CTRL[acr_pkg::CTRL_ATE];
			ie_q     <= acr_pkg::RST_CTRL[acr_pkg::CTRL_IE];
			div_q    <= acr_pkg::RST_CTRL[acr_pkg::CTRL_DIV +: 3];
			trig_q   <= acr_pkg::RST_TRIG;
		end else if (wr) begin
			case (idx)
				acr_pkg::IDX_MUX: begin
					mux_q <= wdat;
				end
				acr_pkg::IDX_TRIG: begin
					trig_q <= wdat[2:0];
				end
				acr_pkg::IDX_CTRL: begin
					// R8 enable bit
					enable_q <= wdat[acr_pkg::CTRL_EN];
					ate_q    <= wdat[acr_pkg::CTRL_ATE];
					ie_q     <= wdat[acr_pkg::CTRL_IE];
					div_q    <= wdat[acr_pkg::CTRL_DIV +: 3];
				end
				default: begin
					mux_q <= mux_q;
				end
			endcase
		end
	end

	// trigger level history; a source switch can make an edge
	always_ff @(posedge clk_i) begin
		if (rst_i)
			trig_prev_q <= 1'b0;
		else
			trig_prev_q <= trigger_i[trig_q];
	end

	// conversion sequencer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q     <= acr_pkg::ST_IDLE;
			need_init_q <= 1'b1;
			len_q       <= acr_pkg::NORMAL_CYCLES;
			cnt_q       <= 5'h00;
		end else if (!en_next) begin
			// R8 disable aborts
			state_q     <= acr_pkg::ST_IDLE;
			need_init_q <= 1'b1;
			cnt_q       <= 5'h00;
		end else begin
			case (state_q)
				acr_pkg::ST_IDLE: begin
					if (start_go) begin
						// R10 initialising length
						state_q     <= acr_pkg::ST_CONV;
						len_q       <= need_init_q ? acr_pkg::FIRST_CYCLES
						                           : acr_pkg::NORMAL_CYCLES;
						need_init_q <= 1'b0;
						cnt_q       <= 5'h00;
					end
				end
				acr_pkg::ST_CONV: begin
					if (conv_done) begin
						// R11 start bit drops unless free running
						state_q <= free_run ? acr_pkg::ST_CONV : acr_pkg::ST_IDLE;
						len_q   <= acr_pkg::NORMAL_CYCLES;
						cnt_q   <= 5'h00;
					end else if (tick && cnt_q != len_q) begin
						cnt_q <= cnt_q + 5'h01;
					end
				end
				default: begin
					state_q <= acr_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// core strobes follow the sequencer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			core_sample_o <= 1'b0;
			core_init_o   <= 1'b0;
		end else begin
			core_sample_o <= (start_go | (conv_done & free_run)) & en_next;
			if (start_go)
				core_init_o <= need_init_q;
			else if (conv_done || !en_next)
				core_init_o <= 1'b0;
		end
	end

	// R1 R7 selection applied only between conversions
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			chan_q            <= acr_pkg::RST_MUX[4:0];
			core_ref_o        <= acr_pkg::REF_EXT_PIN;
			core_int_ref_on_o <= 1'b0;
			core_kind_o       <= acr_pkg::IN_SINGLE;
			core_pos_o        <= 3'h0;
			core_neg_o        <= 2'h0;
			core_gain_o       <= acr_pkg::GAIN_1X;
		end else if (!busy || conv_done) begin
			chan_q <= mux_q[acr_pkg::MUX_CHAN +: 5];
			// R2 reference decode
			core_ref_o        <= acr_pkg::acr_ref_type'(mux_q[acr_pkg::MUX_REF +: 2]);
			core_int_ref_on_o <= mux_q[acr_pkg::MUX_REF + 1];
			// R5 R6 channel and gain decode
			core_kind_o <= kind_of(mux_q[4:0]);
			core_pos_o  <= mux_q[2:0];
			core_neg_o  <= 2'h0;
			core_gain_o <= acr_pkg::GAIN_1X;
			if (mux_q[4:3] == 2'h1) begin
				core_pos_o  <= {1'b0, mux_q[2], mux_q[0]};
				core_neg_o  <= mux_q[2] ? 2'h2 : 2'h0;
				core_gain_o <= mux_q[1] ? acr_pkg::GAIN_200X : acr_pkg::GAIN_10X;
			end else if (mux_q[4] && kind_of(mux_q[4:0]) == acr_pkg::IN_DIFF) begin
				core_neg_o <= mux_q[3] ? 2'h2 : 2'h1;
			end
		end
	end

	// R13 result capture, R17 sign form for differential
	always_ff @(posedge clk_i) begin
		if (rst_i)
			result_q <= acr_pkg::RST_RESULT;
		else if (res_write)
			result_q <= (kind_of(chan_q) == acr_pkg::IN_DIFF)
				? {~core_result_i[9], core_result_i[8:0]} : core_result_i;
	end

	// R18 byte lock across the two result reads
	always_ff @(posedge clk_i) begin
		if (rst_i)
			lock_q <= 1'b0;
		else if (req && !wb_we_i && idx == acr_pkg::IDX_RES_HI)
			lock_q <= 1'b0;
		else if (req && !wb_we_i && idx == acr_pkg::IDX_RES_LO)
			lock_q <= 1'b1;
	end

	// R14 done flag; a completion beats a clear
	always_ff @(posedge clk_i) begin
		if (rst_i)
			flag_q <= acr_pkg::RST_CTRL[acr_pkg::CTRL_FLAG];
		else if (res_write)
			flag_q <= 1'b1;
		else if (irq_ack_i || (wr_ctrl && wdat[acr_pkg::CTRL_FLAG]))
			flag_q <= 1'b0;
	end

	// R15 interrupt request
	always_ff @(posedge clk_i) begin
		if (rst_i)
			irq_o <= 1'b0;
		else
			irq_o <= flag_q & ie_q & global_irq_en_i;
	end

	// core enable and clock mirror
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			core_enable_o <= 1'b0;
			core_clk_en_o <= 1'b0;
			core_busy_o   <= 1'b0;
		end else begin
			core_enable_o <= enable_q;
			core_clk_en_o <= tick;
			core_busy_o   <= busy;
		end
	end

	// bus acknowledge and read data, one cycle after the request
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= req;
			wb_dat_o <= 32'h0000_0000;
			if (req && !wb_we_i && wb_adr_i[11:10] == 2'h0) begin
				case (idx)
					// R3 R4 R19 R20 R21 live alignment
					acr_pkg::IDX_RES_LO: begin
						wb_dat_o[7:0] <= shown[7:0];
					end
					acr_pkg::IDX_RES_HI: begin
						wb_dat_o[7:0] <= shown[15:8];
					end
					acr_pkg::IDX_CTRL: begin
						// R11 start reads busy
						wb_dat_o[7:0] <= {enable_q, busy, ate_q, flag_q, ie_q, div_q};
					end
					acr_pkg::IDX_TRIG: begin
						wb_dat_o[2:0] <= trig_q;
					end
					acr_pkg::IDX_MUX: begin
						wb_dat_o[7:0] <= mux_q;
					end
					default: begin
						wb_dat_o <= 32'h0000_0000;
					end
				endcase
			end
		end
	end

	// checks
	property p_flag_set;
		@(posedge clk_i) disable iff (rst_i) res_write |=> flag_q && result_q == $past(
			(kind_of(chan_q) == acr_pkg::IN_DIFF) ? {~core_result_i[9], core_result_i[8:0]}
			: core_result_i);
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("flag or result not updated"); // R13
	property p_flag_clr;
		@(posedge clk_i) disable iff (rst_i) irq_ack_i && !res_write |=> !flag_q;
	endproperty
	a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared"); // R14
	property p_irq;
		@(posedge clk_i) disable iff (rst_i) irq_o == $past(flag_q && ie_q && global_irq_en_i);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt gating wrong"); // R15
	property p_abort;
		@(posedge clk_i) disable iff (rst_i) wr_ctrl && !wdat[acr_pkg::CTRL_EN] |=> !busy ##1 !core_busy_o;
	endproperty
	a_abort: assert property (p_abort) else $error("disable did not abort"); // R8
	property p_start;
		@(posedge clk_i) disable iff (rst_i) start_go |=> busy && core_sample_o && cnt_q == 5'h00;
	endproperty
	a_start: assert property (p_start) else $error("start not taken"); // R9
	property p_first_len;
		@(posedge clk_i) disable iff (rst_i) start_go |=> len_q == ($past(need_init_q) ? 5'h19 : 5'h0D);
	endproperty
	a_first_len: assert property (p_first_len) else $error("conversion length wrong"); // R10
	property p_left;
		@(posedge clk_i) disable iff (rst_i) req && !wb_we_i && idx == acr_pkg::IDX_RES_HI
			&& mux_q[acr_pkg::MUX_LEFT] |=> wb_ack_o && wb_dat_o[7:0] == $past(result_q[9:2]);
	endproperty
	a_left: assert property (p_left) else $error("left aligned high byte wrong"); // R21
	property p_right;
		@(posedge clk_i) disable iff (rst_i) req && !wb_we_i && idx == acr_pkg::IDX_RES_HI
			&& !mux_q[acr_pkg::MUX_LEFT] |=> wb_dat_o[7:0] == {6'h00, $past(result_q[9:8])};
	endproperty
	a_right: assert property (p_right) else $error("right aligned high byte wrong"); // R20
	property p_lock;
		@(posedge clk_i) disable iff (rst_i) lock_q && conv_done |=> $stable(result_q) && !$rose(flag_q);
	endproperty
	a_lock: assert property (p_lock) else $error("locked result changed"); // R18
	property p_hold;
		@(posedge clk_i) disable iff (rst_i) busy && !conv_done ##1 busy |-> $stable(core_pos_o)
			&& $stable(core_ref_o);
	endproperty
	a_hold: assert property (p_hold) else $error("selection changed mid conversion"); // R7
	c_convert: cover property (@(posedge clk_i) disable iff (rst_i) start_go ##[1:1000] res_write);
	c_lock: cover property (@(posedge clk_i) disable iff (rst_i) lock_q && conv_done);
	c_freerun: cover property (@(posedge clk_i) disable iff (rst_i) conv_done && free_run);
endmodule // acr_adc_ctrl

// ### verif/acr_core_model.sv
`timescale 1ns/100ps
// behavioural analog core: answers 3 clocks, or 400 with slow_i, after each sample pulse
module acr_core_model (
	input  wire logic       clk_i,    // system clock
	input  wire logic       rst_i,    // synchronous reset
	input  wire logic       slow_i,   // long conversion time
	input  wire logic       sample_i, // sample pulse from control
	input  wire logic [1:0] kind_i,   // input kind
	input  wire logic [2:0] pos_i,    // positive input
	input  wire logic [1:0] neg_i,    // negative input
	input  wire logic [1:0] gain_i,   // gain
	output logic            done_o,   // result ready
	output logic [9:0]      result_o  // raw result
);
	logic [9:0] cnt_q; // cycles since the last sample
	logic [9:0] res_q; // code of the selection in use
	always_ff @(posedge clk_i) begin
		if (rst_i || sample_i) begin
			cnt_q <= 10'h000;
		end else if (!done_o) begin
			cnt_q <= cnt_q + 10'h001;
		end
	end
	// code built from the selection, offset binary when differential
	always_ff @(posedge clk_i) begin
		res_q <= {1'b1, kind_i, pos_i, (kind_i == 2'h1) ? {gain_i, neg_i} : 4'h0};
	end
	assign done_o = (cnt_q >= (slow_i ? 10'h190 : 10'h003));
	// lines not yet valid show the inverse of the code
	assign result_o = done_o ? res_q : ~res_q;
endmodule // acr_core_model

// ### verif/acr_adc_ctrl_tb.sv
`timescale 1ns/100ps
// self-checking bench of the converter control block
module acr_adc_ctrl_tb;
	logic        clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, slow;
	logic        global_irq_en_i, irq_ack_i, irq_o, core_done_i, core_int_ref_on_o;
	logic        core_enable_o, core_clk_en_o, core_sample_o, core_busy_o, core_init_o;
	logic [11:0] wb_adr_i;
	logic [31:0] wb_dat_i, wb_dat_o;
	logic [3:0]  wb_sel_i;
	logic [7:0]  trigger_i, rd;
	logic [9:0]  core_result_i, r;
	logic [2:0]  core_pos_o;
	logic [1:0]  core_neg_o;
	acr_pkg::acr_ref_type  core_ref_o;
	acr_pkg::acr_kind_type core_kind_o;
	acr_pkg::acr_gain_type core_gain_o;
	int          n_fail, compares, len, nsamp, nclk;
	// channel table: code, kind, input, {negative, gain}
	logic [4:0] t_code [11] = '{5'h00, 5'h07, 5'h08, 5'h0B, 5'h0D, 5'h0E, 5'h10, 5'h17, 5'h1D,
		5'h1E, 5'h1F};
	logic [1:0] t_kind [11] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h3};
	logic [2:0] t_pos [11] = '{3'h0, 3'h7, 3'h0, 3'h1, 3'h3, 3'h2, 3'h0, 3'h7, 3'h5, 3'h0, 3'h0};
	logic [3:0] t_ng [11] = '{4'h0, 4'h0, 4'h1, 4'h2, 4'h9, 4'hA, 4'h4, 4'h4, 4'h8, 4'h0, 4'h0};

	acr_adc_ctrl dut (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i,
		.wb_stb_i, .wb_dat_o, .wb_ack_o, .trigger_i, .global_irq_en_i, .irq_ack_i, .irq_o,
		.core_done_i, .core_result_i, .core_enable_o, .core_clk_en_o, .core_sample_o,
		.core_busy_o, .core_init_o, .core_ref_o, .core_int_ref_on_o, .core_kind_o, .core_pos_o,
		.core_neg_o, .core_gain_o);
	acr_core_model core (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .sample_i(core_sample_o),
		.kind_i(core_kind_o), .pos_i(core_pos_o), .neg_i(core_neg_o), .gain_i(core_gain_o),
		.done_o(core_done_i), .result_o(core_result_i));

	// clock, 20 ns period
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	// busy length and sample pulses
	always @(posedge clk_i) begin
		if (core_busy_o === 1'b1) len++;
		if (core_sample_o === 1'b1) nsamp++;
		if (core_clk_en_o === 1'b1 && core_busy_o === 1'b1) nclk++;
	end
	// hang guard
	initial begin
		#1000000;
		n_fail++;
		stop_test();
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// conversion length in system clocks for n ticks of divide d
	task automatic span(input int n, input int d);
		compares++;
		if (len < (n - 1) * d || len > n * d + 3) begin
			n_fail++;
			$display("Error at %0t: length %0d for %0d ticks of %0d", $time, len, n, d);
		end
	endtask
	// one classic bus cycle, waits for ack
	task automatic acc(input logic [7:0] idx, input logic we, input logic [7:0] wd);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_adr_i <= {2'h0, idx, 2'h0};
		wb_we_i <= we;
		wb_dat_i <= {24'h0, wd};
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		rd = wb_dat_o[7:0];
		chk({7'h0, wb_ack_o}, 8'h01);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
		acc(idx, 1'b1, wd);
	endtask
	task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
		acc(idx, 1'b0, 8'h00);
		chk(rd, exp);
	endtask
	// wait until the running conversion ends
	task automatic idle_wait();
		int n;
		n = 0;
		repeat (3) @(posedge clk_i);
		while (core_busy_o === 1'b1 && n < 5000) begin
			@(posedge clk_i);
			n++;
		end
		chk({7'h0, core_busy_o}, 8'h00);
	endtask
	task automatic conv(input logic [7:0] ctl);
		len = 0;
		nsamp = 0;
		nclk = 0;
		wr(8'h7A, ctl);
		idle_wait();
	endtask
	// result as stored: differential codes get bit 9 turned over
	function automatic logic [9:0] res(input logic [1:0] k, input logic [2:0] p,
		input logic [3:0] gn);
		res = {k != 2'h1, k, p, (k == 2'h1) ? gn : 4'h0};
	endfunction
	task automatic rres(input logic [9:0] v, input logic left);
		rdchk(8'h78, left ? {v[1:0], 6'h00} : v[7:0]);
		rdchk(8'h79, left ? v[9:2] : {6'h00, v[9:8]});
	endtask
	task automatic stop_test();
		if (n_fail == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		rst_i = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 12'h000;
		wb_dat_i = 32'h0;
		wb_sel_i = 4'hF;
		trigger_i = 8'h00;
		global_irq_en_i = 1'b0;
		irq_ack_i = 1'b0;
		slow = 1'b0;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		// reset values, read-only and unmapped places
		for (int i = 8'h78; i < 8'h7D; i++) rdchk(i[7:0], 8'h00);
		wr(8'h78, 8'hFF);
		rdchk(8'h78, 8'h00);
		rdchk(8'h79, 8'h00);
		rdchk(8'h7E, 8'h00);
		// channel and reference decoding while idle
		for (int i = 0; i < 11; i++) begin
			wr(8'h7C, {3'h0, t_code[i]});
			repeat (3) @(posedge clk_i);
			chk({6'h0, core_kind_o}, {6'h0, t_kind[i]});
			if (t_kind[i] < 2'h2) chk({5'h0, core_pos_o}, {5'h0, t_pos[i]});
			if (t_kind[i] == 2'h1) chk({4'h0, core_neg_o, core_gain_o}, {4'h0, t_ng[i]});
		end
		for (int i = 0; i < 4; i++) begin
			wr(8'h7C, {i[1:0], 6'h00});
			repeat (3) @(posedge clk_i);
			chk({5'h0, core_int_ref_on_o, core_ref_o}, {5'h0, i[1], i[1:0]});
		end
		// first conversion started together with enable
		wr(8'h7C, 8'h03);
		conv(8'hC0);
		span(25, 2);
		rdchk(8'h7A, 8'h90);
		r = res(2'h0, 3'h3, 4'h0);
		rres(r, 1'b0);
		wr(8'h7C, 8'h23);
		rres(r, 1'b1);
		wr(8'h7A, 8'h80);
		rdchk(8'h7A, 8'h90);
		wr(8'h7A, 8'h90);
		rdchk(8'h7A, 8'h80);
		// every prescaler code, one start per write
		for (int i = 0; i < 8; i++) begin
			conv({5'b11010, i[2:0]});
			span(13, (i < 2) ? 2 : (1 << i));
			chk(nsamp[7:0], 8'h01);
			chk(nclk[7:0], 8'h0D);
		end
		// selection written mid-conversion waits for its end
		wr(8'h7C, 8'hC9);
		slow <= 1'b1;
		wr(8'h7A, 8'hD0);
		repeat (20) @(posedge clk_i);
		wr(8'h7C, 8'h42);
		repeat (3) @(posedge clk_i);
		chk({3'h0, core_ref_o, core_pos_o}, {3'h0, 2'h3, 3'h1});
		rdchk(8'h7A, 8'hC0);
		idle_wait();
		slow <= 1'b0;
		repeat (2) @(posedge clk_i);
		chk({3'h0, core_ref_o, core_pos_o}, {3'h0, 2'h1, 3'h2});
		rres(res(2'h1, 3'h1, 4'h4), 1'b0);
		// low byte read holds the result until the high byte
		wr(8'h7C, 8'h05);
		conv(8'hD0);
		r = res(2'h0, 3'h5, 4'h0);
		rdchk(8'h78, r[7:0]);
		wr(8'h7C, 8'h06);
		conv(8'hD0);
		rdchk(8'h7A, 8'h80);
		rdchk(8'h79, {6'h00, r[9:8]});
		conv(8'hD0);
		rres(res(2'h0, 3'h6, 4'h0), 1'b0);
		// zero to start ignored, disable aborts
		wr(8'h7A, 8'hD7);
		repeat (10) @(posedge clk_i);
		chk({7'h0, core_init_o}, 8'h00);
		wr(8'h7A, 8'h87);
		rdchk(8'h7A, 8'hC7);
		wr(8'h7A, 8'h07);
		repeat (3) @(posedge clk_i);
		chk({6'h0, core_busy_o, core_enable_o}, 8'h00);
		rdchk(8'h7A, 8'h07);
		len = 0;
		wr(8'h7A, 8'hC0);
		chk({7'h0, core_init_o}, 8'h01);
		idle_wait();
		span(25, 2);
		// interrupt needs flag, enable and global enable
		conv(8'hD8);
		repeat (2) @(posedge clk_i);
		chk({7'h0, irq_o}, 8'h00);
		global_irq_en_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk({7'h0, irq_o}, 8'h01);
		wr(8'h7A, 8'h80);
		repeat (3) @(posedge clk_i);
		chk({7'h0, irq_o}, 8'h00);
		wr(8'h7A, 8'h88);
		irq_ack_i <= 1'b1;
		@(posedge clk_i);
		irq_ack_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk({7'h0, irq_o}, 8'h00);
		rdchk(8'h7A, 8'h88);
		// each trigger source, others must not start
		for (int s = 1; s < 8; s++) begin
			wr(8'h7B, {5'h00, s[2:0]});
			rdchk(8'h7B, {5'h00, s[2:0]});
			wr(8'h7A, 8'hB0);
			trigger_i <= 8'hFE & ~(8'h01 << s);
			repeat (4) @(posedge clk_i);
			chk({7'h0, core_busy_o}, 8'h00);
			trigger_i <= 8'hFE;
			repeat (4) @(posedge clk_i);
			chk({7'h0, core_busy_o}, 8'h01);
			idle_wait();
			trigger_i <= 8'h00;
		end
		// free running restarts after one start write
		wr(8'h7B, 8'h00);
		nsamp = 0;
		wr(8'h7A, 8'hF0);
		repeat (150) @(posedge clk_i);
		chk({7'h0, nsamp >= 5 && nsamp <= 7}, 8'h01);
		wr(8'h7A, 8'h90);
		idle_wait();
		stop_test();
	end
endmodule // acr_adc_ctrl_tb
